/* shared/dtmf_port_map.svh */
`ifndef DTMF_PORT_MAP_SVH
`define DTMF_PORT_MAP_SVH

// control register a fields
`define CRA_TONE_BIT 0
`define CRA_CP_BIT 1
`define CRA_IRQ_BIT 2
`define CRA_SECOND_SEL_BIT 3
// control register b fields
`define CRB_BURST_N_BIT 0
`define CRB_TEST_BIT 1
`define CRB_SINGLE_BIT 2
`define CRB_COL_BIT 3
// status register fields
`define ST_IRQ_BIT 0
`define ST_TXRDY_BIT 1
`define ST_RXFULL_BIT 2
`define ST_STEER_BIT 3
// reset values and programming words
`define CR_RESET 4'h0
`define CRA_SW_RESET 4'h8
`define CRA_RUN 4'hd
`define CRB_RUN 4'h0
`define ST_RESET 4'h0
// timing
`define CLK_HZ 10000000
`define BURST_TIME_MS 50
`define BURST_CYCLES (`BURST_TIME_MS * (`CLK_HZ / 1000))
`define INIT_STEPS 8

`endif

/* shared/dtmf_pkg.sv */
package dtmf_pkg;

  // transmitter burst sequencer
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_TONE,
    TX_PAUSE
  } tx_state_t;

  // host access sequencer
  typedef enum logic [3:0] {
    H_OFF,
    H_INIT_ACC,
    H_INIT_WAIT,
    H_IDLE,
    H_ST_RD,
    H_ST_WAIT,
    H_RX_RD,
    H_RX_WAIT,
    H_TX_WR
  } host_state_t;

endpackage

/* shared/dtmf_bus_if.sv */
`timescale 1ns/1ps
interface dtmf_bus_if;
  logic cs_n;
  logic register_select_line;
  logic rw;
  logic [3:0] host_d;
  logic host_oe;
  logic [3:0] dev_d;
  logic dev_oe;
  logic irq_oe;
  logic [3:0] bus_d;
  logic interrupt_progress_output_n;

  // data bus resolution, pulled high when nobody drives
  assign bus_d = host_oe ? host_d : (dev_oe ? dev_d : 4'hf);
  // open-drain interrupt line
  assign interrupt_progress_output_n = ~irq_oe;

  modport device (input cs_n, input register_select_line, input rw, input bus_d,
                  output dev_d, output dev_oe, output irq_oe);
  modport host (output cs_n, output register_select_line, output rw, output host_d,
                output host_oe, input bus_d, input interrupt_progress_output_n);
endinterface

/* rtl/dtmf_port_device.sv */
`timescale 1ns/1ps
`include "dtmf_port_map.svh"
// Operation
// - host soft-resets port after power-up
// - select, register select, read/write decode four registers
// - control a 1101 enables tone, DTMF, interrupt
// - zero to control b picks dual-tone burst
// - digit written as four-bit transmit code
// - status bit 1 marks transmitter ready
// - status bit 2 marks digit received
// - host reads receive data before transmit write
// - burst is 50 ms tone, 50 ms pause
// - ready flag only 100 ms after write
// - status read clears irq, ready, full flags
// - control a bit 3 routes only next write to b
// - interrupt pin low on receive or ready
module dtmf_port_device
  import dtmf_pkg::*;
#(
  parameter int unsigned BURST_CYCLES = `BURST_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  dtmf_bus_if.device bus,
  input wire logic i_rx_valid,
  input wire logic [3:0] i_rx_code,
  input wire logic i_rx_steering,
  output logic o_tone_active,
  output logic [3:0] o_tone_code,
  output logic o_single_tone,
  output logic o_column_tone
);

  // access decode
  logic acc;
  logic ctl_wr;
  logic st_rd;
  logic tx_wr;
  logic rx_rd;

  // register state
  logic [3:0] cra_q;
  logic [3:0] crb_q;
  logic second_control_select_q;
  logic [3:0] tx_code_q;
  logic [3:0] rx_code_q;
  logic rdy_q;
  logic full_q;
  logic irq_q;
  logic [3:0] rd_data_q;
  logic rd_oe_q;
  logic irq_oe_q;
  logic tone_q;

  // burst sequencer
  tx_state_t tx_state_q;
  logic [20:0] cnt_q;
  logic [20:0] phase_end;
  logic burst_mode;
  logic dtmf_mode;
  logic phase_done;
  logic tx_done;
  logic [3:0] status;

  // a one-cycle low select marks one access
  assign acc = ~bus.cs_n;
  assign ctl_wr = acc & bus.register_select_line & ~bus.rw;
  assign st_rd = acc & bus.register_select_line & bus.rw;
  assign tx_wr = acc & ~bus.register_select_line & ~bus.rw;
  assign rx_rd = acc & ~bus.register_select_line & bus.rw;

  // mode decode from the control registers
  assign burst_mode = ~crb_q[`CRB_BURST_N_BIT];
  assign dtmf_mode = ~cra_q[`CRA_CP_BIT];

  // call progress mode doubles both burst and pause
  assign phase_end = cra_q[`CRA_CP_BIT] ? 21'(BURST_CYCLES * 2 - 1)
                                        : 21'(BURST_CYCLES - 1);
  assign phase_done = (cnt_q == phase_end);

  // end of pause, unless a fresh write restarts the burst
  assign tx_done = (tx_state_q == TX_PAUSE) & phase_done & ~tx_wr & burst_mode;

  // status word as seen by the host
  always_comb begin
    status = `ST_RESET;
    status[`ST_IRQ_BIT] = irq_q;
    status[`ST_TXRDY_BIT] = rdy_q;
    status[`ST_RXFULL_BIT] = full_q;
    status[`ST_STEER_BIT] = i_rx_steering;
  end

  // control registers and the one-shot select of register b
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cra_q <= `CR_RESET;
      crb_q <= `CR_RESET;
      second_control_select_q <= 1'b0;
    end else if (ctl_wr) begin
      if (second_control_select_q) begin
        crb_q <= bus.bus_d;
        second_control_select_q <= 1'b0;
      end else begin
        cra_q <= bus.bus_d;
        second_control_select_q <= bus.bus_d[`CRA_SECOND_SEL_BIT];
      end
    end
  end

  // transmit code latch, passed straight to the tone generator
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_code_q <= 4'h0;
    end else if (tx_wr) begin
      tx_code_q <= bus.bus_d;
    end
  end

  // burst and pause timing
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_state_q <= TX_IDLE;
      cnt_q <= 21'h0;
    end else if (!burst_mode) begin
      tx_state_q <= TX_IDLE;
      cnt_q <= 21'h0;
    end else if (tx_wr) begin
      tx_state_q <= TX_TONE;
      cnt_q <= 21'h0;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          cnt_q <= 21'h0;
        end
        TX_TONE: begin
          if (phase_done) begin
            tx_state_q <= TX_PAUSE;
            cnt_q <= 21'h0;
          end else begin
            cnt_q <= cnt_q + 21'h1;
          end
        end
        TX_PAUSE: begin
          if (phase_done) begin
            tx_state_q <= TX_IDLE;
            cnt_q <= 21'h0;
          end else begin
            cnt_q <= cnt_q + 21'h1;
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
          cnt_q <= 21'h0;
        end
      endcase
    end
  end

  // transmitter ready flag, set wins over the read clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdy_q <= 1'b0;
    end else if (tx_done) begin
      rdy_q <= 1'b1;
    end else if (st_rd || tx_wr || !burst_mode) begin
      rdy_q <= 1'b0;
    end
  end

  // receive data latch and full flag
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_code_q <= 4'h0;
      full_q <= 1'b0;
    end else if (i_rx_valid) begin
      rx_code_q <= i_rx_code;
      full_q <= 1'b1;
    end else if (st_rd) begin
      full_q <= 1'b0;
    end
  end

  // interrupt-occurred flag follows either event
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_q <= 1'b0;
    end else if (tx_done || i_rx_valid) begin
      irq_q <= 1'b1;
    end else if (st_rd) begin
      irq_q <= 1'b0;
    end
  end

  // read data driven for the cycle after the access
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_data_q <= 4'h0;
      rd_oe_q <= 1'b0;
    end else begin
      rd_oe_q <= st_rd | rx_rd;
      rd_data_q <= st_rd ? status : rx_code_q;
    end
  end

  // interrupt pin pulls low; test mode shows steering instead
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_oe_q <= 1'b0;
    end else if (crb_q[`CRB_TEST_BIT]) begin
      irq_oe_q <= dtmf_mode & i_rx_steering;
    end else begin
      irq_oe_q <= dtmf_mode & cra_q[`CRA_IRQ_BIT] & irq_q;
    end
  end

  // tone output gating
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tone_q <= 1'b0;
    end else if (burst_mode) begin
      tone_q <= cra_q[`CRA_TONE_BIT] & (tx_state_q == TX_TONE);
    end else begin
      tone_q <= cra_q[`CRA_TONE_BIT];
    end
  end

  assign bus.dev_d = rd_data_q;
  assign bus.dev_oe = rd_oe_q;
  assign bus.irq_oe = irq_oe_q;
  assign o_tone_active = tone_q;
  assign o_tone_code = tx_code_q;
  assign o_single_tone = crb_q[`CRB_SINGLE_BIT];
  assign o_column_tone = crb_q[`CRB_COL_BIT];

endmodule // dtmf_port_device

/* rtl/dtmf_port_host.sv */
`timescale 1ns/1ps
`include "dtmf_port_map.svh"
module dtmf_port_host
  import dtmf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  dtmf_bus_if.host bus,
  input wire logic i_start,
  input wire logic i_tx_valid,
  input wire logic [3:0] i_tx_digit,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [3:0] o_rx_digit,
  output logic o_init_done
);

  host_state_t st_q;
  logic [2:0] idx_q;
  logic [3:0] stat_q;
  logic [3:0] pend_code_q;
  logic pend_q;
  logic tx_ok_q;
  logic done_q;
  logic rx_v_q;
  logic [3:0] rx_d_q;
  logic [5:0] op;

  // init step table: {rs, rw, data}
  function automatic logic [5:0] init_op(input logic [2:0] i);
    unique case (i)
      3'h0: init_op = {2'b11, 4'h0};
      3'h1: init_op = {2'b10, `CR_RESET};
      3'h2: init_op = {2'b10, `CR_RESET};
      3'h3: init_op = {2'b10, `CRA_SW_RESET};
      3'h4: init_op = {2'b10, `CR_RESET};
      3'h5: init_op = {2'b11, 4'h0};
      3'h6: init_op = {2'b10, `CRA_RUN};
      3'h7: init_op = {2'b10, `CRB_RUN};
    endcase
  endfunction

  assign op = init_op(idx_q);

  // bus drive decoded from the sequencer state
  always_comb begin
    bus.cs_n = 1'b1;
    bus.register_select_line = 1'b0;
    bus.rw = 1'b1;
    bus.host_d = 4'h0;
    bus.host_oe = 1'b0;
    unique case (st_q)
      H_INIT_ACC: begin
        bus.cs_n = 1'b0;
        bus.register_select_line = op[5];
        bus.rw = op[4];
        bus.host_d = op[3:0];
        bus.host_oe = ~op[4];
      end
      H_ST_RD: begin
        bus.cs_n = 1'b0;
        bus.register_select_line = 1'b1;
      end
      H_RX_RD: begin
        bus.cs_n = 1'b0;
      end
      H_TX_WR: begin
        bus.cs_n = 1'b0;
        bus.rw = 1'b0;
        bus.host_d = pend_code_q;
        bus.host_oe = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // access sequencer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= H_OFF;
      idx_q <= 3'h0;
      stat_q <= 4'h0;
    end else begin
      unique case (st_q)
        H_OFF: if (i_start) st_q <= H_INIT_ACC;
        H_INIT_ACC: st_q <= H_INIT_WAIT;
        H_INIT_WAIT: begin
          idx_q <= idx_q + 3'h1;
          st_q <= (idx_q == 3'(`INIT_STEPS - 1)) ? H_IDLE : H_INIT_ACC;
        end
        H_IDLE: begin
          if (!bus.interrupt_progress_output_n || (pend_q && !tx_ok_q)) begin
            st_q <= H_ST_RD;
          end else if (pend_q && tx_ok_q) begin
            st_q <= H_TX_WR;
          end
        end
        H_ST_RD: st_q <= H_ST_WAIT;
        H_ST_WAIT: begin
          stat_q <= bus.bus_d;
          if (bus.bus_d[`ST_RXFULL_BIT]) begin
            st_q <= H_RX_RD;
          end else if (bus.bus_d[`ST_TXRDY_BIT] && pend_q) begin
            st_q <= H_TX_WR;
          end else begin
            st_q <= H_IDLE;
          end
        end
        H_RX_RD: st_q <= H_RX_WAIT;
        H_RX_WAIT: st_q <= (stat_q[`ST_TXRDY_BIT] && pend_q) ? H_TX_WR : H_IDLE;
        H_TX_WR: st_q <= H_IDLE;
      endcase
    end
  end

  // ready-seen flag gates the transmit write started from H_IDLE
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_ok_q <= 1'b0;
    end else if (st_q == H_TX_WR) begin
      tx_ok_q <= 1'b0;
    end else if ((st_q == H_ST_WAIT && bus.bus_d[`ST_TXRDY_BIT]) || st_q == H_INIT_WAIT) begin
      tx_ok_q <= 1'b1;
    end
  end

  // one pending digit from the user side
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend_q <= 1'b0;
      pend_code_q <= 4'h0;
    end else if (i_tx_valid && o_tx_ready) begin
      pend_q <= 1'b1;
      pend_code_q <= i_tx_digit;
    end else if (st_q == H_TX_WR) begin
      pend_q <= 1'b0;
    end
  end

  // received digit out, init status
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_v_q <= 1'b0;
      rx_d_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      rx_v_q <= (st_q == H_RX_WAIT);
      if (st_q == H_RX_WAIT) rx_d_q <= bus.bus_d;
      if (st_q == H_IDLE) done_q <= 1'b1;
    end
  end

  assign o_tx_ready = done_q & ~pend_q;
  assign o_rx_valid = rx_v_q;
  assign o_rx_digit = rx_d_q;
  assign o_init_done = done_q;

endmodule // dtmf_port_host

/* sim/dtmf_port_monitor.sv */
`timescale 1ns/1ps
module dtmf_port_monitor #(
  parameter int unsigned BURST_CYCLES = 20
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic cs_n,
  input wire logic register_select_line,
  input wire logic rw,
  input wire logic [3:0] host_d,
  input wire logic host_oe,
  input wire logic [3:0] dev_d,
  input wire logic dev_oe,
  input wire logic irq_oe
);
  localparam logic [7:0] INIT_RD = 8'h21;
  localparam logic [31:0] INIT_D = 32'h0d008000;
  logic st_q, seen_q, wrote_q;
  logic [3:0] n_q;
  logic [31:0] cnt_q;
  wire tx_wr = !cs_n && !register_select_line && !rw;
  wire rx_rd = !cs_n && !register_select_line && rw;
  wire st_ans = dev_oe && st_q;
  // status answer marker and init access count
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= 1'b0;
      n_q <= 4'h0;
    end else begin
      st_q <= !cs_n && register_select_line && rw;
      if (!cs_n && n_q < 4'h8) n_q <= n_q + 4'h1;
    end
  end
  // time since last tx write, ready seen since then
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seen_q <= 1'b0;
      wrote_q <= 1'b0;
      cnt_q <= 32'h0;
    end else if (tx_wr) begin
      seen_q <= 1'b0;
      wrote_q <= 1'b1;
      cnt_q <= 32'h0;
    end else begin
      if (st_ans && dev_d[1]) seen_q <= 1'b1;
      if (cnt_q != 32'hffffffff) cnt_q <= cnt_q + 32'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  read_answer_a: assert property (!cs_n && rw |=> dev_oe ##1 !dev_oe)
    else $error("read access without one-cycle answer");
  answer_cause_a: assert property (dev_oe |-> $past(!cs_n && rw))
    else $error("answer without read access");
  write_drive_a: assert property (!cs_n && !rw |-> host_oe && !dev_oe)
    else $error("write without host driving");
  single_strobe_a: assert property (!cs_n |=> cs_n)
    else $error("access strobe longer than one cycle");
  init_order_a: assert property (!cs_n && n_q < 4'h8 |-> register_select_line
    && rw == INIT_RD[n_q] && (rw || host_d == INIT_D[{n_q, 2'b00} +: 4]))
    else $error("init access sequence wrong");
  ready_early_a: assert property (st_ans && cnt_q <= 2 * BURST_CYCLES |-> !dev_d[1])
    else $error("ready flag before burst and pause ended");
  ready_cleared_a: assert property (st_ans && seen_q |-> !dev_d[1])
    else $error("ready flag not cleared by status read");
  tx_after_ready_a: assert property (tx_wr && wrote_q |-> seen_q)
    else $error("tx write before ready seen");
  rx_first_a: assert property (st_ans && dev_d[2] |-> !tx_wr throughout ##[1:20] rx_rd)
    else $error("received digit not read first");
  irq_cause_a: assert property ($rose(irq_oe) |-> ##[0:8] st_ans && (dev_d[1] || dev_d[2]))
    else $error("interrupt without flag");
  cover property (st_ans && dev_d[2:1] == 2'b11);
  cover property (st_ans && dev_d[1]);
  cover property ($rose(irq_oe));
endmodule // dtmf_port_monitor

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int B = 20;
  logic i_clk = 0, i_nrst = 0, i_start = 0, i_tx_valid = 0, i_rx_valid = 0;
  logic i_rx_steering = 0, prev_st_rd = 0, rdy_seen = 0;
  logic [3:0] i_tx_digit = 4'h0, i_rx_code = 4'h0, exp_rx = 4'h0;
  logic o_tx_ready, o_rx_valid, o_init_done, o_tone_active, o_single_tone, o_column_tone;
  logic [3:0] o_rx_digit, o_tone_code;
  logic [31:0] seed = 32'ha1e57e94;
  int failures = 0, comparisons = 0, rx_sent = 0, rx_got = 0, n, tone;
  always #50 i_clk = ~i_clk;
  dtmf_bus_if bus_if ();
  dtmf_port_device #(.BURST_CYCLES(B)) dtmf_port_device_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .bus(bus_if), .i_rx_valid(i_rx_valid), .i_rx_code(i_rx_code),
    .i_rx_steering(i_rx_steering), .o_tone_active(o_tone_active), .o_tone_code(o_tone_code),
    .o_single_tone(o_single_tone), .o_column_tone(o_column_tone));
  dtmf_port_host dtmf_port_host_inst (.i_clk(i_clk), .i_nrst(i_nrst), .bus(bus_if),
    .i_start(i_start), .i_tx_valid(i_tx_valid), .i_tx_digit(i_tx_digit),
    .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid), .o_rx_digit(o_rx_digit),
    .o_init_done(o_init_done));
  dtmf_port_monitor #(.BURST_CYCLES(B)) dtmf_port_monitor_inst (.i_clk(i_clk),
    .i_nrst(i_nrst), .cs_n(bus_if.cs_n), .register_select_line(bus_if.register_select_line),
    .rw(bus_if.rw), .host_d(bus_if.host_d), .host_oe(bus_if.host_oe),
    .dev_d(bus_if.dev_d), .dev_oe(bus_if.dev_oe), .irq_oe(bus_if.irq_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step();
    @(posedge i_clk);
    #10;
  endtask
  task automatic chk_val(input string what, input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_cnt(input string what, input int e, input int g);
    comparisons++;
    if (g != e) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // received digits reach the host user side
  always @(negedge i_clk) begin
    if (o_rx_valid === 1'b1) begin
      rx_got++;
      chk_val("rx digit", exp_rx, o_rx_digit);
    end
  end
  task automatic reset_port();
    i_nrst = 0;
    repeat (10) step();
    chk_val("tone idle in reset", 0, o_tone_active);
    i_nrst = 1;
  endtask
  task automatic init_port();
    i_start = 1;
    step();
    i_start = 0;
    n = 0;
    while (o_init_done !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    chk_val("init done", 1, o_init_done);
    if (n >= 100) end_of_test();
    chk_val("single tone", 0, o_single_tone);
    chk_val("column tone", 0, o_column_tone);
    $display("test init finished");
  endtask
  task automatic send(input logic [3:0] d, input int rx_at);
    chk_val("tx ready", 1, o_tx_ready);
    i_tx_valid = 1;
    i_tx_digit = d;
    step();
    i_tx_valid = 0;
    n = 0;
    // wait for the host to put the code on the bus
    while (!(bus_if.cs_n === 1'b0 && bus_if.register_select_line === 1'b0
        && bus_if.rw === 1'b0) && n < 400) begin
      step();
      n++;
    end
    chk_cnt("tx write wait bound", 1, n < 400);
    chk_val("tx write data", d, bus_if.host_d);
    if (n >= 400) end_of_test();
    n = 0;
    tone = 0;
    prev_st_rd = 0;
    rdy_seen = 0;
    // count from the write until a status answer shows ready
    while (rdy_seen !== 1'b1 && n < 400) begin
      seed = lfsr(seed);
      i_rx_valid = (n == rx_at);
      i_rx_code = seed[3:0];
      i_rx_steering = seed[4];
      if (n == rx_at) begin
        exp_rx = seed[3:0];
        rx_sent++;
      end
      step();
      n++;
      tone += o_tone_active;
      if (n == 8) chk_val("tone code", d, o_tone_code);
      rdy_seen = prev_st_rd & bus_if.dev_oe & bus_if.dev_d[1];
      prev_st_rd = ~bus_if.cs_n & bus_if.register_select_line & bus_if.rw;
    end
    i_rx_valid = 0;
    chk_cnt("ready wait bound", 1, n < 400);
    if (n >= 400) end_of_test();
    chk_cnt("tone cycles", B, tone);
    chk_cnt("ready delay in range", 1, n >= 2 * B && n <= 2 * B + 24);
    $display("test digit %h finished", d);
  endtask
  initial begin
    reset_port();
    init_port();
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      send(k == 0 ? 4'h7 : (k == 1 ? 4'h5 : seed[3:0]), k == 0 ? 2 * B - 1 : 1 + seed[9:4] % 30);
    end
    reset_port();
    init_port();
    send(seed[7:4], 2 * B - 1);
    repeat (10) step();
    chk_cnt("rx count", rx_sent, rx_got);
    end_of_test();
  end
endmodule // testbench
